// ---- rtl/tdp_defines.svh ----
// constants for the tape diagnostic parameter block
// assumes inclusion by bare name from rtl files
`ifndef TDP_DEFINES_SVH
`define TDP_DEFINES_SVH
`define TDP_N_MIN 8'h01
`define TDP_N_MAX 8'hff
`define TDP_N_DEF 8'h32
`define TDP_LEN_MIN 4'h0
`define TDP_LEN_MAX 4'hf
`define TDP_LEN_DEF 4'hc
`define TDP_PAT_DEF 2'h3
`define TDP_PAT_LAST 2'h3
`define TDP_FAIL_MAX 8'hff
`define TDP_LOOP_MAX 14'h270f
`define TDP_MSG_MS 1000
`define TDP_CLK_MHZ 125
`define TDP_ADDR_N 12'h000
`define TDP_ADDR_LEN 12'h004
`define TDP_ADDR_MODE 12'h008
`define TDP_ADDR_CMD 12'h00c
`define TDP_ADDR_STAT 12'h010
`define TDP_ADDR_CNT 12'h014
`define TDP_ADDR_PANEL 12'h018
`define TDP_CMD_HOST_N 0
`define TDP_CMD_HOST_END 1
`define TDP_CMD_FSKIP 2
`define TDP_CMD_LOOP_INC 3
`define TDP_CMD_LOOP_CLR 4
`define TDP_CMD_ERR 5
`define TDP_CMD_ENTRY 6
`define TDP_CMD_HI 7
`define TDP_CMD_LO 8
`define TDP_CMD_STREAM 9
`define TDP_CMD_NOSTREAM 10
`define TDP_CMD_QUEUED 11
`define TDP_CMD_UNQUEUE 12
`endif

// ---- rtl/tdp_param_ctrl.sv ----
// parameter and counter logic for tape diagnostic programs
// assumes apb master on core_clk; panel buttons are one-cycle presses
`timescale 1ns/1ns
`include "tdp_defines.svh"
module tdp_param_ctrl
  import tdp_pkg::*;
#(
  parameter int MSG_CYCLES = `TDP_MSG_MS * `TDP_CLK_MHZ * 1000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tdp_buttons_s buttons,
  input wire logic density_3200,
  input wire logic block_done,
  output tdp_params_s params,
  output tdp_pat_e main_pattern,
  output logic reposition,
  output logic abort_program,
  output logic speed_msg_hi,
  output logic speed_msg_lo,
  output logic [7:0] failure_count_byte_a,
  output logic [7:0] failure_count_byte_b,
  output logic [13:0] loop_count,
  output logic [3:0] block_size_display,
  output logic [7:0] shown_n,
  output tdp_state_e entry_state
);
  typedef struct packed {
    tdp_params_s p;
    tdp_pat_e main_pat;
    logic main_pat_fixed;
    logic [7:0] saved_n;
    logic host_active;
    logic fskip;
    logic queued;
    tdp_state_e st;
    logic [7:0] edit_n;
    logic [3:0] edit_len;
    tdp_pat_e edit_pat;
    logic [31:0] msg_cnt;
    logic msg_hi;
    logic msg_lo;
    logic repos;
    logic abort;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } tdp_state_s;

  tdp_state_s r;
  tdp_state_s next_r;
  logic [12:0] cmd;
  logic fail_inc;
  logic [7:0] fail_b;
  logic [13:0] loops;
  logic acc;
  logic [7:0] wn;
  logic [3:0] wl;
  logic tick;
  // short sim runs fall back to one tick per clock
  localparam int TICK_DIV = (MSG_CYCLES >= `TDP_MSG_MS)
                            ? MSG_CYCLES / `TDP_MSG_MS : 1;
  localparam int MSG_TICKS = MSG_CYCLES / TICK_DIV;
  assign acc = psel && penable && !r.ready;
  assign wn = pwdata[7:0];
  assign wl = pwdata[3:0];

  assign cmd = (acc && pwrite && paddr == `TDP_ADDR_CMD) ? pwdata[12:0]
               : '0;
  assign fail_inc = cmd[`TDP_CMD_ERR] && r.fskip && r.queued;

  always_comb
  begin
    next_r = r;
    next_r.ready = acc;
    next_r.err = 1'b0;
    next_r.abort = 1'b0;
    next_r.repos = !r.p.streaming && block_done;
    if (r.msg_cnt != '0)
      next_r.msg_cnt = r.msg_cnt - 32'(tick);
    else
    begin
      next_r.msg_hi = 1'b0;
      next_r.msg_lo = 1'b0;
    end
    if (acc && pwrite)
    begin
      case (paddr)
        `TDP_ADDR_N:
          if (wn >= `TDP_N_MIN && wn <= `TDP_N_MAX)
            next_r.p.repeat_n = wn;
          else
            next_r.err = 1'b1;
        `TDP_ADDR_LEN:
          next_r.p.len_log2 = wl;
        `TDP_ADDR_MODE:
        begin
          if (!r.main_pat_fixed)
            next_r.main_pat = tdp_pat_e'(pwdata[1:0]);
          next_r.p.pattern = tdp_pat_e'(pwdata[1:0]);
        end
        `TDP_ADDR_CMD:
          ;
        default:
          next_r.err = 1'b1;
      endcase
    end
    else if (acc)
    begin
      case (paddr)
        `TDP_ADDR_N:
          next_r.rdata = {24'h0, r.p.repeat_n};
        `TDP_ADDR_LEN:
          next_r.rdata = {28'h0, r.p.len_log2};
        `TDP_ADDR_MODE:
          next_r.rdata = {28'h0, r.p.streaming, r.p.high_speed,
                          r.p.pattern};
        `TDP_ADDR_CMD:
          next_r.rdata = '0;
        `TDP_ADDR_STAT:
          next_r.rdata = {16'h0, fail_b, failure_count_byte_a};
        `TDP_ADDR_CNT:
          next_r.rdata = {18'h0, loops};
        `TDP_ADDR_PANEL:
          next_r.rdata = {24'h0, r.fskip, r.queued, r.host_active,
                          r.msg_hi, r.msg_lo, 1'b0, r.st};
        default:
        begin
          next_r.rdata = '0;
          next_r.err = 1'b1;
        end
      endcase
    end
    if (cmd[`TDP_CMD_HOST_N])
    begin
      if (pwdata[20:13] >= `TDP_N_MIN)
      begin
        if (!r.host_active)
          next_r.saved_n = r.p.repeat_n;
        next_r.host_active = 1'b1;
        next_r.p.repeat_n = pwdata[20:13];
      end
      else
        next_r.err = 1'b1;
    end
    if (cmd[`TDP_CMD_HOST_END] && r.host_active)
    begin
      next_r.host_active = 1'b0;
      next_r.p.repeat_n = r.saved_n;
    end
    if (cmd[`TDP_CMD_QUEUED])
      next_r.queued = 1'b1;
    if (cmd[`TDP_CMD_UNQUEUE])
    begin
      next_r.queued = 1'b0;
      next_r.fskip = 1'b0;
    end
    // skip mode is ignored outside a queued list
    if (cmd[`TDP_CMD_FSKIP] && r.queued)
      next_r.fskip = 1'b1;
    if (fail_inc)
      next_r.abort = 1'b1;
    if (cmd[`TDP_CMD_HI])
    begin
      if (density_3200)
        next_r.err = 1'b1;
      else
      begin
        next_r.p.high_speed = 1'b1;
        next_r.msg_hi = 1'b1;
        next_r.msg_lo = 1'b0;
        next_r.msg_cnt = 32'(MSG_TICKS);
      end
    end
    if (cmd[`TDP_CMD_LO])
    begin
      next_r.p.high_speed = 1'b0;
      next_r.msg_lo = 1'b1;
      next_r.msg_hi = 1'b0;
      next_r.msg_cnt = 32'(MSG_TICKS);
    end
    // density change forces the low speed back
    if (density_3200 && r.p.high_speed)
      next_r.p.high_speed = 1'b0;
    if (cmd[`TDP_CMD_STREAM])
      next_r.p.streaming = 1'b1;
    if (cmd[`TDP_CMD_NOSTREAM])
      next_r.p.streaming = 1'b0;
    if (cmd[`TDP_CMD_ENTRY] && r.st == TDP_ST_IDLE)
    begin
      next_r.st = TDP_ST_N;
      next_r.edit_n = r.p.repeat_n;
    end
    case (r.st)
      TDP_ST_IDLE:
        ;
      TDP_ST_N:
      begin
        if (buttons.density)
        begin
          next_r.st = TDP_ST_LEN;
          next_r.edit_len = r.p.len_log2;
        end
        else if (buttons.run_stop)
        begin
          next_r.p.repeat_n = r.edit_n;
          next_r.st = TDP_ST_LEN;
          next_r.edit_len = r.p.len_log2;
        end
        else if (buttons.tens)
          next_r.edit_n = (r.edit_n > `TDP_N_MAX - 8'd10) ? `TDP_N_MAX
                          : r.edit_n + 8'd10;
        else if (buttons.units || buttons.step)
          next_r.edit_n = (r.edit_n == `TDP_N_MAX) ? `TDP_N_MIN
                          : r.edit_n + 8'd1;
      end
      TDP_ST_LEN:
      begin
        if (buttons.density)
        begin
          next_r.st = TDP_ST_PAT;
          next_r.edit_pat = r.p.pattern;
        end
        else if (buttons.run_stop)
        begin
          next_r.p.len_log2 = r.edit_len;
          next_r.st = TDP_ST_PAT;
          next_r.edit_pat = r.p.pattern;
        end
        else if (buttons.tens && r.edit_len != `TDP_LEN_MAX)
          next_r.edit_len = r.edit_len + 4'h1;
        else if (buttons.units && r.edit_len != `TDP_LEN_MIN)
          next_r.edit_len = r.edit_len - 4'h1;
      end
      TDP_ST_PAT:
      begin
        if (buttons.density || buttons.run_stop)
        begin
          next_r.p.pattern = r.edit_pat;
          next_r.main_pat = r.edit_pat;
          next_r.main_pat_fixed = 1'b1;
          next_r.st = TDP_ST_IDLE;
        end
        else if (buttons.units)
          next_r.edit_pat = tdp_pat_e'(r.edit_pat + 2'h1);
      end
      default:
        next_r.st = TDP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.p.repeat_n <= `TDP_N_DEF;
      r.p.len_log2 <= `TDP_LEN_DEF;
      r.p.pattern <= tdp_pat_e'(`TDP_PAT_DEF);
      r.main_pat <= tdp_pat_e'(`TDP_PAT_DEF);
      r.p.streaming <= 1'b0;
      r.st <= TDP_ST_IDLE;
    end
    else
      r <= next_r;
  end

  tdp_sat_cnt #(.W(8), .MAX(`TDP_FAIL_MAX)) u_fail_b (
    .core_clk(core_clk),
    .rst(rst),
    .clr(1'b0),
    .inc(fail_inc),
    .count(fail_b)
  );

  tdp_sat_cnt #(.W(14), .MAX(`TDP_LOOP_MAX)) u_loop (
    .core_clk(core_clk),
    .rst(rst),
    .clr(cmd[`TDP_CMD_LOOP_CLR]),
    .inc(cmd[`TDP_CMD_LOOP_INC] && r.queued),
    .count(loops)
  );

  tdp_tick #(.DIV(TICK_DIV)) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick)
  );

  // non-apb outputs one stage behind state; counter copies clear one edge late
  always_ff @(posedge core_clk)
  begin
    failure_count_byte_a <= fail_b;
    failure_count_byte_b <= fail_b;
    loop_count <= loops;
    params <= r.p;
    main_pattern <= r.main_pat;
    reposition <= r.repos;
    abort_program <= r.abort;
    speed_msg_hi <= r.msg_hi;
    speed_msg_lo <= r.msg_lo;
    block_size_display <= (r.st == TDP_ST_LEN) ? r.edit_len : r.p.len_log2;
    shown_n <= (r.st == TDP_ST_N) ? r.edit_n : r.p.repeat_n;
    entry_state <= r.st;
  end
  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.err;
endmodule : tdp_param_ctrl

// ---- rtl/tdp_pkg.sv ----
// types for the tape diagnostic parameter block
// assumes tdp_defines.svh is on the include path
package tdp_pkg;
  typedef enum logic [1:0] {
    TDP_PAT_ZERO = 2'h0,
    TDP_PAT_ONES = 2'h1,
    TDP_PAT_ALT = 2'h2,
    TDP_PAT_RAND = 2'h3
  } tdp_pat_e;
  typedef enum logic [1:0] {
    TDP_ST_IDLE = 2'h0,
    TDP_ST_N = 2'h1,
    TDP_ST_LEN = 2'h2,
    TDP_ST_PAT = 2'h3
  } tdp_state_e;
  typedef struct packed {
    logic step;
    logic tens;
    logic units;
    logic density;
    logic run_stop;
  } tdp_buttons_s;
  typedef struct packed {
    logic [7:0] repeat_n;
    logic [3:0] len_log2;
    tdp_pat_e pattern;
    logic streaming;
    logic high_speed;
  } tdp_params_s;
endpackage : tdp_pkg

// ---- rtl/tdp_sat_cnt.sv ----
// saturating up counter with synchronous clear
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
module tdp_sat_cnt #(
  parameter int W = 8,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] count
);
  always_ff @(posedge core_clk)
  begin
    if (rst || clr)
      count <= '0;
    else if (inc && count != MAX)
      count <= count + 1'b1;
  end
endmodule : tdp_sat_cnt

// ---- rtl/tdp_tick.sv ----
// one-cycle pulse every DIV clocks
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ns
module tdp_tick #(
  parameter int DIV = 125000
) (
  input wire logic core_clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else if (cnt == 32'(DIV - 1))
    begin
      cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : tdp_tick

// ---- sim/tb_tdp_param_ctrl.sv ----
// self-checking bench for the parameter block
// assumes checker bound in its own file; panel model presses keys
`timescale 1ns/1ns
`include "tdp_defines.svh"
module tb_tdp_param_ctrl
  import tdp_pkg::*;
;
  logic core_clk = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, go = 0, err;
  logic density_3200 = 0, block_done = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h2f21, q[$];
  logic pready, pslverr, reposition, abort_program;
  logic speed_msg_hi, speed_msg_lo;
  logic [7:0] failure_count_byte_a, failure_count_byte_b, shown_n;
  logic [13:0] loop_count;
  logic [3:0] block_size_display;
  tdp_buttons_s req = '0, buttons;
  tdp_params_s params;
  tdp_pat_e main_pattern;
  tdp_state_e entry_state;
  int n_mismatch = 0, n_tests = 0, n_abort = 0;
  tdp_panel_model pm (.core_clk(core_clk), .go(go), .req(req),
    .buttons(buttons));
  tdp_param_ctrl #(.MSG_CYCLES(100)) uut (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .buttons(buttons), .density_3200(density_3200),
    .block_done(block_done), .params(params), .main_pattern(main_pattern),
    .reposition(reposition), .abort_program(abort_program),
    .speed_msg_hi(speed_msg_hi), .speed_msg_lo(speed_msg_lo),
    .failure_count_byte_a(failure_count_byte_a),
    .failure_count_byte_b(failure_count_byte_b), .loop_count(loop_count),
    .block_size_display(block_size_display), .shown_n(shown_n),
    .entry_state(entry_state));
  initial forever #4 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic chk(input logic [31:0] s, e, input string nm);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge core_clk); while (pready !== 1'b1);
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(0, a, '0);
  endtask : rdchk
  task automatic press(input logic [4:0] b);
    @(posedge core_clk);
    req <= b;
    go <= 1;
    @(posedge core_clk);
    go <= 0;
    repeat (3) @(posedge core_clk);
  endtask : press
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // read results are compared in order of issue
  always @(posedge core_clk)
  begin
    seed <= xs(seed);
    block_done <= seed[2:0] == 3'h0 && !rst;
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk(prdata, q.pop_front(), "prdata");
    if (abort_program === 1'b1)
      n_abort++;
  end
  initial
  begin
    #600000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    logic [31:0] v, e;
    repeat (12) @(posedge core_clk);
    rst <= 0;
    repeat (2) @(posedge core_clk);
    rdchk(`TDP_ADDR_N, 32'h32);
    rdchk(`TDP_ADDR_LEN, 32'hc);
    rdchk(`TDP_ADDR_MODE, 32'h3);
    rdchk(`TDP_ADDR_STAT, '0);
    rdchk(`TDP_ADDR_CNT, '0);
    apb(1, `TDP_ADDR_N, '0);
    chk(err, 1, "n0 err");
    v = {24'h0, seed[7:0] | 8'h01};
    apb(1, `TDP_ADDR_N, v);
    rdchk(`TDP_ADDR_N, v);
    apb(1, `TDP_ADDR_CMD, 32'he001);
    rdchk(`TDP_ADDR_N, 32'h7);
    apb(1, `TDP_ADDR_CMD, 32'h2);
    rdchk(`TDP_ADDR_N, v);
    rdchk(12'h01c, '0);
    chk(err, 1, "unmapped");
    $display("params done");
    density_3200 <= 1;
    apb(1, `TDP_ADDR_CMD, 32'h80);
    chk(err, 1, "hi3200");
    density_3200 <= 0;
    apb(1, `TDP_ADDR_CMD, 32'h80);
    repeat (2) @(posedge core_clk);
    chk(params.high_speed, 1, "hi");
    chk(speed_msg_hi, 1, "msghi");
    repeat (120) @(posedge core_clk);
    chk(speed_msg_hi, 0, "msgoff");
    apb(1, `TDP_ADDR_CMD, 32'h100);
    repeat (2) @(posedge core_clk);
    chk(speed_msg_lo, 1, "msglo");
    apb(1, `TDP_ADDR_CMD, 32'h200);
    repeat (30) @(posedge core_clk);
    apb(1, `TDP_ADDR_CMD, 32'h400);
    repeat (30) @(posedge core_clk);
    $display("speed done");
    apb(1, `TDP_ADDR_CMD, 32'h800);
    apb(1, `TDP_ADDR_CMD, 32'h4);
    for (int i = 0; i < 10001; i++)
      apb(1, `TDP_ADDR_CMD, i < 300 ? 32'h28 : 32'h8);
    repeat (4) @(posedge core_clk);
    chk(n_abort, 300, "aborts");
    rdchk(`TDP_ADDR_STAT, 32'hffff);
    rdchk(`TDP_ADDR_CNT, 32'h270f);
    apb(1, `TDP_ADDR_CMD, 32'h1010);
    rdchk(`TDP_ADDR_CNT, '0);
    $display("counters done");
    apb(1, `TDP_ADDR_CMD, 32'h40);
    repeat (2) @(posedge core_clk);
    chk(entry_state, TDP_ST_N, "st n");
    press(5'b00010);
    chk(entry_state, TDP_ST_LEN, "st len");
    press(5'b01000);
    chk(block_size_display, 4'hd, "len x2");
    press(5'b00010);
    chk(entry_state, TDP_ST_PAT, "st pat");
    press(5'b00100);
    press(5'b00001);
    chk(main_pattern, TDP_PAT_ZERO, "pat");
    chk(entry_state, TDP_ST_IDLE, "st idle");
    apb(1, `TDP_ADDR_MODE, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(main_pattern, TDP_PAT_ZERO, "pat kept");
    e = v == 32'hff ? 32'h1 : v + 32'h1;
    apb(1, `TDP_ADDR_CMD, 32'h40);
    press(5'b00100);
    chk(shown_n, e, "shown");
    press(5'b00001);
    chk(params.repeat_n, e, "n now");
    $display("panel done");
    report_and_stop;
  end
endmodule : tb_tdp_param_ctrl

// ---- sim/tdp_panel_model.sv ----
// operator model: one-cycle button presses on request
// assumes requests arrive right after a rising edge
`timescale 1ns/1ns
module tdp_panel_model
  import tdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic go,
  input wire tdp_buttons_s req,
  output tdp_buttons_s buttons
);
  // a finger never holds a key past one cycle here
  always_ff @(posedge core_clk)
  begin
    buttons <= go ? req : '0;
  end
endmodule : tdp_panel_model

// ---- sim/tdp_param_ctrl_asserts.sv ----
// concurrent checks on the parameter block outputs
// assumes bind into tdp_param_ctrl; params lag one edge
`timescale 1ns/1ns
module tdp_param_ctrl_asserts
  import tdp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic density_3200,
  input wire logic block_done,
  input wire tdp_params_s params,
  input wire logic reposition,
  input wire logic speed_msg_hi,
  input wire logic [7:0] failure_count_byte_a,
  input wire logic [7:0] failure_count_byte_b,
  input wire logic [13:0] loop_count,
  input wire tdp_buttons_s buttons,
  input wire tdp_state_e entry_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  repo_stop_a: assert property (
    block_done && !params.streaming ##1 !params.streaming[*2] |-> reposition)
    else $error("no reposition after block");
  repo_stream_a: assert property (
    block_done && params.streaming ##1 params.streaming[*2] |-> !reposition)
    else $error("reposition while streaming");
  n_range_a: assert property (params.repeat_n != 8'h00)
    else $error("repeat count zero");
  hi_3200_a: assert property (
    density_3200[*3] |-> !params.high_speed)
    else $error("high speed at 3200");
  fail_pair_a: assert property (
    failure_count_byte_a == failure_count_byte_b)
    else $error("failure bytes differ");
  fail_step_a: assert property ($changed(failure_count_byte_a) |->
    failure_count_byte_a == $past(failure_count_byte_a) + 8'h01)
    else $error("failure byte jump");
  fail_sat_a: assert property (
    failure_count_byte_a == 8'hff |=> failure_count_byte_a == 8'hff)
    else $error("failure byte wrapped");
  loop_step_a: assert property ($changed(loop_count) |->
    loop_count == $past(loop_count) + 14'h1 || loop_count == 14'h0)
    else $error("loop count jump");
  loop_max_a: assert property (loop_count <= 14'h270f)
    else $error("loop count past max");
  msg_hold_a: assert property (
    $rose(speed_msg_hi) |-> speed_msg_hi[*8])
    else $error("speed message too short");
  entry_skip_a: assert property (
    entry_state == TDP_ST_N && buttons.density |-> ##[1:2]
    entry_state == TDP_ST_LEN)
    else $error("skip did not advance");
  cover property (reposition);
  cover property ($rose(speed_msg_hi));
  cover property (failure_count_byte_a == 8'hff);
endmodule : tdp_param_ctrl_asserts

bind tdp_param_ctrl tdp_param_ctrl_asserts chk_i (.core_clk(core_clk),
  .rst(rst), .density_3200(density_3200), .block_done(block_done),
  .params(params), .reposition(reposition), .speed_msg_hi(speed_msg_hi),
  .failure_count_byte_a(failure_count_byte_a),
  .failure_count_byte_b(failure_count_byte_b), .loop_count(loop_count),
  .buttons(buttons), .entry_state(entry_state));
